// ===== hw/sncl_pkg.sv
// Purpose: shared constants and types for the strap/nvm configuration latch
// Assumes: strap pins arrive already digitised by analog sensing outside this block
// Notes:   register byte offsets are word aligned on a 32-bit apb bus
package sncl_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] SNCL_CTRL_ADDR    = 8'h00;
	localparam logic [7:0] SNCL_STATUS_ADDR  = 8'h04;
	localparam logic [7:0] SNCL_FREQ_ADDR    = 8'h08;
	localparam logic [7:0] SNCL_MLOAD_ADDR   = 8'h0C;
	localparam logic [7:0] SNCL_BOOT_ADDR    = 8'h10;
	localparam logic [7:0] SNCL_VLIM_ADDR    = 8'h14;
	localparam logic [7:0] SNCL_SHOOT_ADDR   = 8'h18;
	localparam logic [7:0] SNCL_SLEWM_ADDR   = 8'h1C;
	localparam logic [7:0] SNCL_RAMP_ADDR    = 8'h20;
	localparam logic [7:0] SNCL_ADDR_ADDR    = 8'h24;
	localparam logic [7:0] SNCL_PHASE_ADDR   = 8'h28;
	localparam logic [7:0] SNCL_OCF_ADDR     = 8'h2C;
	localparam logic [7:0] SNCL_SETPT_ADDR   = 8'h30;

	// ==========================================================
	// field positions
	localparam int SNCL_FREQ_LSB     = 4;
	localparam int SNCL_MODE_DAC     = 7;
	localparam int SNCL_MODE_ILV     = 6;
	localparam int SNCL_MODE_DPS     = 4;
	localparam int SNCL_MODE_ZLL     = 3;
	localparam int SNCL_CTRL_RELOAD  = 0;

	// ==========================================================
	// reset values and phase count codes
	localparam logic [7:0] SNCL_BYTE_RST  = 8'h00;
	localparam logic [2:0] SNCL_PH_MAX    = 3'h4;
	localparam logic [2:0] SNCL_PH_ONE    = 3'h1;
	localparam logic [2:0] SNCL_PH_TWO    = 3'h2;
	localparam logic [2:0] SNCL_PH_THREE  = 3'h3;
	// fault threshold = max load * 5 / 4
	localparam int SNCL_OCF_MUL = 5;
	localparam int SNCL_OCF_SHR = 2;

	// ==========================================================
	// strap source resistance classes from the analog front end
	typedef enum logic [1:0] {
		SNCL_SRC_LOW  = 2'b01,
		SNCL_SRC_HIGH = 2'b10
	} sncl_src_e;

	typedef enum logic [2:0] {
		SNCL_ST_WAIT = 3'b001,
		SNCL_ST_LOAD = 3'b010,
		SNCL_ST_RUN  = 3'b100
	} sncl_state_e;

	// digitised strap readings: r = resistor code, v = voltage code
	typedef struct packed {
		logic [2:0] freq_r;
		logic [7:0] mload_v;
		logic [2:0] boot_r;
		logic [3:0] boot_v;
		logic [3:0] vlim_r;
		logic [3:0] vlim_v;
		logic [2:0] oshoot_r;
		logic [2:0] ushoot_v;
		logic [2:0] slew_r;
		logic [3:0] mode_v;
		logic [2:0] addr_r;
		logic [3:0] addr_v;
	} sncl_strap_s;

	// stored nonvolatile image
	typedef struct packed {
		logic [3:0] freq;
		logic [7:0] mload;
		logic [7:0] boot;
		logic [3:0] vlim;
		logic [2:0] oshoot;
		logic [2:0] ushoot;
		logic [2:0] slew;
		logic [4:0] mode;
		logic [1:0] rise;
		logic [1:0] ramp;
	} sncl_nvm_s;

	// assembled configuration
	typedef struct packed {
		logic [7:0] freq_cfg;
		logic [7:0] mload;
		logic [7:0] boot;
		logic [3:0] vlim;
		logic [2:0] oshoot;
		logic [2:0] ushoot;
		logic [2:0] slew;
		logic [7:0] mode;
		logic [1:0] rise;
		logic [1:0] ramp;
		logic [3:0] addr;
	} sncl_cfg_s;

endpackage : sncl_pkg

// ===== hw/sncl_decode.sv
// Purpose: assemble configuration from straps or nvm image
// Assumes: strap codes are stable while sampled
// Notes:   purely combinational
`timescale 1ns/1ps
module sncl_decode (
	// inputs
	input  wire sncl_pkg::sncl_strap_s strap,
	input  wire sncl_pkg::sncl_nvm_s   nvm,
	input  wire logic                  use_strap,
	// assembled result
	output sncl_pkg::sncl_cfg_s        cfg
);

	// ==========================================================
	// decode
	always_comb begin
		cfg = '0;
		if (use_strap) begin
			cfg.freq_cfg[sncl_pkg::SNCL_FREQ_LSB +: 3] = strap.freq_r;
			cfg.mload  = strap.mload_v;
			cfg.boot   = {strap.boot_v, strap.boot_r, strap.addr_r[0]};
			cfg.vlim   = strap.vlim_r ^ strap.vlim_v;
			cfg.oshoot = strap.oshoot_r;
			cfg.ushoot = strap.ushoot_v;
			cfg.slew = strap.slew_r;
			cfg.mode[sncl_pkg::SNCL_MODE_DAC] = strap.mode_v[3];
			cfg.mode[sncl_pkg::SNCL_MODE_ILV] = strap.mode_v[2];
			cfg.mode[sncl_pkg::SNCL_MODE_DPS] = strap.mode_v[1];
			cfg.mode[sncl_pkg::SNCL_MODE_ZLL] = strap.mode_v[0];
			cfg.rise = strap.addr_r[2:1];
			cfg.ramp = strap.vlim_v[3:2];
		end else begin
			cfg.freq_cfg[sncl_pkg::SNCL_FREQ_LSB +: 4] = nvm.freq;
			cfg.mload  = nvm.mload;
			cfg.boot   = nvm.boot;
			cfg.vlim   = nvm.vlim;
			cfg.oshoot = nvm.oshoot;
			cfg.ushoot = nvm.ushoot;
			cfg.slew = nvm.slew;
			cfg.mode[7:3] = nvm.mode;
			cfg.rise = nvm.rise;
			cfg.ramp = nvm.ramp;
		end
		cfg.addr = strap.addr_v;
	end

endmodule : sncl_decode

// ===== hw/sncl_phase_detect.sv
// Purpose: maximum active phase count from sense inputs tied to the rail
// Assumes: tie flags come from comparators outside
// Notes:   lowest tied input wins
`timescale 1ns/1ps
module sncl_phase_detect (
	// tie detection
	input  wire logic       ph2_tied,
	input  wire logic       ph3_tied,
	input  wire logic       ph4_tied,
	// result
	output logic      [2:0] max_phases
);

	always_comb begin
		if (ph2_tied)
			max_phases = sncl_pkg::SNCL_PH_ONE;
		else if (ph3_tied)
			max_phases = sncl_pkg::SNCL_PH_TWO;
		else if (ph4_tied)
			max_phases = sncl_pkg::SNCL_PH_THREE;
		else
			max_phases = sncl_pkg::SNCL_PH_MAX;
	end

endmodule : sncl_phase_detect

// ===== hw/sncl_top.sv
// Purpose: latch power-up configuration from straps or nvm, expose over apb
// Assumes: rail-good is synchronous; strap codes digitised externally
// Notes:   capture on rising edge of aux rail good; apb writes override fields
`timescale 1ns/1ps

module sncl_top (
	// clock and reset
	input  wire  logic                  pclk,
	input  wire  logic                  presetn,
	// apb slave
	input  wire  logic                  psel,
	input  wire  logic                  penable,
	input  wire  logic                  pwrite,
	input  wire  logic [7:0]            paddr,
	input  wire  logic [31:0]           pwdata,
	output logic       [31:0]           prdata,
	output logic                        pready,
	output logic                        pslverr,
	// power and source straps
	input  wire  logic                  aux_3v3_rail,
	input  wire  sncl_pkg::sncl_src_e   config_source_strap,
	// digitised straps and nvm image
	input  wire  sncl_pkg::sncl_strap_s strap_codes,
	input  wire  sncl_pkg::sncl_nvm_s   nvm_image,
	// phase sense inputs tied to rail
	input  wire  logic                  phase2_current_sense,
	input  wire  logic                  phase3_current_sense,
	input  wire  logic                  phase4_current_sense,
	// live configuration
	output sncl_pkg::sncl_cfg_s         cfg_out,
	output logic       [7:0]            output_setpoint_cmd,
	output logic       [7:0]            output_overcurrent_fault,
	output logic       [2:0]            max_phases,
	output logic                        cfg_valid
);

	// ==========================================================
	// declarations
	sncl_pkg::sncl_state_e state_reg;
	sncl_pkg::sncl_state_e state_next;
	sncl_pkg::sncl_cfg_s   cfg_reg;
	sncl_pkg::sncl_cfg_s   cfg_dec;
	logic [7:0]            setpt_reg;
	logic [7:0]            ocf_reg;
	logic [2:0]            phase_reg;
	logic [2:0]            phase_dec;
	logic                  rail_reg;
	logic                  reload_reg;
	logic                  rail_rise;
	logic                  capture;
	logic                  wr_en;
	logic                  addr_ok;
	logic [7:0]            wbyte;
	logic [9:0]            ocf_calc;
	logic [31:0]           rd_mux;

	// ==========================================================
	// sub blocks
	sncl_decode u_decode (
		.strap     (strap_codes),
		.nvm       (nvm_image),
		.use_strap (config_source_strap == sncl_pkg::SNCL_SRC_LOW),
		.cfg       (cfg_dec)
	);

	sncl_phase_detect u_phase (
		.ph2_tied   (phase2_current_sense),
		.ph3_tied   (phase3_current_sense),
		.ph4_tied   (phase4_current_sense),
		.max_phases (phase_dec)
	);

	// ==========================================================
	// power-up sequencing
	assign rail_rise = aux_3v3_rail & ~rail_reg;
	assign capture   = (state_reg == sncl_pkg::SNCL_ST_LOAD);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rail_reg <= 1'b0;
		else
			rail_reg <= aux_3v3_rail;
	end

	// rail drop returns to wait so the next power-up recaptures
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			sncl_pkg::SNCL_ST_WAIT: begin
				if (rail_rise)
					state_next = sncl_pkg::SNCL_ST_LOAD;
			end
			sncl_pkg::SNCL_ST_LOAD: begin
				state_next = sncl_pkg::SNCL_ST_RUN;
			end
			sncl_pkg::SNCL_ST_RUN: begin
				if (!aux_3v3_rail)
					state_next = sncl_pkg::SNCL_ST_WAIT;
				else if (reload_reg)
					state_next = sncl_pkg::SNCL_ST_LOAD;
			end
			default: begin
				state_next = sncl_pkg::SNCL_ST_WAIT;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_reg <= sncl_pkg::SNCL_ST_WAIT;
		else
			state_reg <= state_next;
	end

	// ==========================================================
	// apb decode
	assign wr_en = psel & penable & pwrite;
	assign wbyte = pwdata[7:0];

	always_comb begin
		addr_ok = 1'b1;
		rd_mux  = '0;
		case (paddr)
			sncl_pkg::SNCL_CTRL_ADDR:   rd_mux = '0;
			sncl_pkg::SNCL_STATUS_ADDR: rd_mux = {29'h0000_0000, state_reg};
			sncl_pkg::SNCL_FREQ_ADDR:   rd_mux = {24'h00_0000, cfg_reg.freq_cfg};
			sncl_pkg::SNCL_MLOAD_ADDR:  rd_mux = {24'h00_0000, cfg_reg.mload};
			sncl_pkg::SNCL_BOOT_ADDR:   rd_mux = {24'h00_0000, cfg_reg.boot};
			sncl_pkg::SNCL_VLIM_ADDR:   rd_mux = {28'h000_0000, cfg_reg.vlim};
			sncl_pkg::SNCL_SHOOT_ADDR:  rd_mux = {25'h000_0000, cfg_reg.ushoot, 1'b0, cfg_reg.oshoot};
			sncl_pkg::SNCL_SLEWM_ADDR:  rd_mux = {24'h00_0000, cfg_reg.mode[7:3], cfg_reg.slew};
			sncl_pkg::SNCL_RAMP_ADDR:   rd_mux = {28'h000_0000, cfg_reg.ramp, cfg_reg.rise};
			sncl_pkg::SNCL_ADDR_ADDR:   rd_mux = {28'h000_0000, cfg_reg.addr};
			sncl_pkg::SNCL_PHASE_ADDR:  rd_mux = {29'h0000_0000, phase_reg};
			sncl_pkg::SNCL_OCF_ADDR:    rd_mux = {24'h00_0000, ocf_reg};
			sncl_pkg::SNCL_SETPT_ADDR:  rd_mux = {24'h00_0000, setpt_reg};
			default:                    addr_ok = 1'b0;
		endcase
	end

	// zero-wait slave: ready in every access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_ok;
			if (psel & ~penable & ~pwrite)
				prdata <= addr_ok ? rd_mux : '0;
		end
	end

	// writes land at the completing edge only
	logic wr_go;
	assign wr_go = wr_en & pready & addr_ok;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			reload_reg <= 1'b0;
		else
			reload_reg <= wr_go && (paddr == sncl_pkg::SNCL_CTRL_ADDR) && pwdata[sncl_pkg::SNCL_CTRL_RELOAD];
	end

	// ==========================================================
	// configuration store
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= '0;
		end else if (capture) begin
			cfg_reg <= cfg_dec;
		end else if (wr_go) begin
			case (paddr)
				sncl_pkg::SNCL_FREQ_ADDR:  cfg_reg.freq_cfg <= wbyte;
				sncl_pkg::SNCL_MLOAD_ADDR: cfg_reg.mload    <= wbyte;
				sncl_pkg::SNCL_BOOT_ADDR:  cfg_reg.boot     <= wbyte;
				sncl_pkg::SNCL_VLIM_ADDR:  cfg_reg.vlim     <= wbyte[3:0];
				sncl_pkg::SNCL_SHOOT_ADDR: begin
					cfg_reg.oshoot <= wbyte[2:0];
					cfg_reg.ushoot <= wbyte[6:4];
				end
				sncl_pkg::SNCL_SLEWM_ADDR: begin
					cfg_reg.slew      <= wbyte[2:0];
					cfg_reg.mode[7:3] <= wbyte[7:3];
				end
				sncl_pkg::SNCL_RAMP_ADDR: begin
					cfg_reg.rise <= wbyte[1:0];
					cfg_reg.ramp <= wbyte[3:2];
				end
				sncl_pkg::SNCL_ADDR_ADDR:  cfg_reg.addr <= wbyte[3:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			phase_reg <= sncl_pkg::SNCL_PH_MAX;
		else if (capture)
			phase_reg <= phase_dec;
		else if (wr_go && paddr == sncl_pkg::SNCL_PHASE_ADDR)
			phase_reg <= wbyte[2:0];
	end

	// fault threshold saturates at full scale
	assign ocf_calc = 10'((cfg_dec.mload * sncl_pkg::SNCL_OCF_MUL) >> sncl_pkg::SNCL_OCF_SHR);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ocf_reg <= sncl_pkg::SNCL_BYTE_RST;
		else if (capture)
			ocf_reg <= (ocf_calc[9:8] != 2'b00) ? 8'hFF : ocf_calc[7:0];
		else if (wr_go && paddr == sncl_pkg::SNCL_OCF_ADDR)
			ocf_reg <= wbyte;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			setpt_reg <= sncl_pkg::SNCL_BYTE_RST;
		else if (capture)
			setpt_reg <= cfg_dec.boot;
		else if (wr_go && paddr == sncl_pkg::SNCL_SETPT_ADDR)
			setpt_reg <= wbyte;
	end

	// ==========================================================
	// outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_out                  <= '0;
			output_setpoint_cmd      <= sncl_pkg::SNCL_BYTE_RST;
			output_overcurrent_fault <= sncl_pkg::SNCL_BYTE_RST;
			max_phases               <= sncl_pkg::SNCL_PH_MAX;
			cfg_valid                <= 1'b0;
		end else begin
			cfg_out                  <= cfg_reg;
			output_setpoint_cmd      <= setpt_reg;
			output_overcurrent_fault <= ocf_reg;
			max_phases               <= phase_reg;
			cfg_valid                <= (state_reg == sncl_pkg::SNCL_ST_RUN);
		end
	end

endmodule : sncl_top

// ===== dv/sncl_top_properties.sv
// Purpose: concurrent checks on the configuration latch ports
// Assumes: straps are held steady across each capture
// Notes:   bound into every sncl_top instance
`timescale 1ns/1ps
module sncl_top_properties (
	// clock and reset
	input wire logic                  pclk,
	input wire logic                  presetn,
	// apb
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [7:0]            paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	// straps
	input wire logic                  aux_3v3_rail,
	input wire sncl_pkg::sncl_src_e   config_source_strap,
	input wire sncl_pkg::sncl_strap_s strap_codes,
	input wire sncl_pkg::sncl_nvm_s   nvm_image,
	input wire logic                  phase2_current_sense,
	input wire logic                  phase3_current_sense,
	input wire logic                  phase4_current_sense,
	// live configuration
	input wire sncl_pkg::sncl_cfg_s   cfg_out,
	input wire logic [7:0]            output_setpoint_cmd,
	input wire logic [7:0]            output_overcurrent_fault,
	input wire logic [2:0]            max_phases,
	input wire logic                  cfg_valid
);
	// ====================
	// helpers
	logic [10:0] ocf_full;
	assign ocf_full = ({3'b000, cfg_out.mload} * 11'd5) >> 2;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_cap;
		$rose(cfg_valid);
	endsequence
	sequence s_strap;
		s_cap ##0 config_source_strap == sncl_pkg::SNCL_SRC_LOW;
	endsequence
	sequence s_nvm;
		s_cap ##0 config_source_strap != sncl_pkg::SNCL_SRC_LOW;
	endsequence

	// ====================
	// assertions
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_err_unmapped: assert property (psel && !penable && paddr > 8'h30 |=> pready && pslverr)
		else $error("unmapped access not refused");
	a_valid_latency: assert property ($rose(aux_3v3_rail) |-> ##[2:4] $rose(cfg_valid))
		else $error("capture late after rail rise");
	a_strap_boot: assert property (s_strap |-> cfg_out.boot == {strap_codes.boot_v, strap_codes.boot_r,
		strap_codes.addr_r[0]} && cfg_out.rise == strap_codes.addr_r[2:1])
		else $error("boot or rise code wrong");
	a_strap_freq: assert property (s_strap |-> cfg_out.freq_cfg[6:4] == strap_codes.freq_r
		&& cfg_out.mload == strap_codes.mload_v)
		else $error("frequency or max load code wrong");
	a_mode_bits: assert property (s_strap |-> {cfg_out.mode[7:6], cfg_out.mode[4:3]} == strap_codes.mode_v)
		else $error("mode bits wrong");
	a_nvm_source: assert property (s_nvm |-> cfg_out.boot == nvm_image.boot && cfg_out.freq_cfg[7:4] == nvm_image.freq)
		else $error("nvm image not used");
	a_addr_strap: assert property (s_cap |-> cfg_out.addr == strap_codes.addr_v)
		else $error("address not from strap");
	a_ocf_ratio: assert property (s_cap |-> output_overcurrent_fault == (ocf_full > 11'd255 ? 8'hFF : ocf_full[7:0]))
		else $error("fault threshold wrong");
	a_boot_setpt: assert property (s_cap |-> output_setpoint_cmd == cfg_out.boot)
		else $error("setpoint not boot code");
	a_phase_count: assert property (s_cap |-> max_phases == (phase2_current_sense ? sncl_pkg::SNCL_PH_ONE :
		phase3_current_sense ? sncl_pkg::SNCL_PH_TWO : phase4_current_sense ? sncl_pkg::SNCL_PH_THREE :
		sncl_pkg::SNCL_PH_MAX))
		else $error("phase count wrong");
	a_hold_quiet: assert property (cfg_valid && $past(cfg_valid) && !$past(psel) && !$past(psel, 2)
		|-> $stable(cfg_out) && $stable(max_phases))
		else $error("latched config moved");
endmodule : sncl_top_properties

bind sncl_top sncl_top_properties chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.aux_3v3_rail(aux_3v3_rail), .config_source_strap(config_source_strap), .strap_codes(strap_codes),
	.nvm_image(nvm_image), .phase2_current_sense(phase2_current_sense),
	.phase3_current_sense(phase3_current_sense), .phase4_current_sense(phase4_current_sense),
	.cfg_out(cfg_out), .output_setpoint_cmd(output_setpoint_cmd),
	.output_overcurrent_fault(output_overcurrent_fault), .max_phases(max_phases), .cfg_valid(cfg_valid));

// ===== dv/sncl_strap_board.sv
// Purpose: board straps, dividers and nvm image facing the latch
// Assumes: one seed picks every strap, source and nvm reading; ties picks the sense inputs
// Notes:   readings follow the seed at once, also after capture
`timescale 1ns/1ps
module sncl_strap_board (
	// scenario choice
	input  wire logic [7:0]       seed,
	input  wire logic [2:0]       ties,
	// board side
	output sncl_pkg::sncl_src_e   config_source_strap,
	output sncl_pkg::sncl_strap_s strap_codes,
	output sncl_pkg::sncl_nvm_s   nvm_image,
	output logic                  phase2_current_sense,
	output logic                  phase3_current_sense,
	output logic                  phase4_current_sense
);
	logic [47:0] rep;
	assign rep = {6{seed}};
	// seed bit 7 picks the high-resistance class
	assign config_source_strap = seed[7] ? sncl_pkg::SNCL_SRC_HIGH : sncl_pkg::SNCL_SRC_LOW;
	assign strap_codes = sncl_pkg::sncl_strap_s'(rep[45:0]);
	assign nvm_image = sncl_pkg::sncl_nvm_s'(~rep[47:6]);
	// a sense input tied to the aux rail reads high
	assign {phase4_current_sense, phase3_current_sense, phase2_current_sense} = ties;
endmodule : sncl_strap_board

// ===== dv/tb_top.sv
// Purpose: self-checking bench for the configuration latch
// Assumes: straps held steady across each capture
// Notes:   expected values come from the board seed
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) begin \
			mismatches++; \
			$display("MISMATCH %s expected %h seen %h", nm, (exp), (got)); \
		end \
	end
module tb_top;
	// ====================
	// signals
	logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, rail, cfg_valid, err;
	logic [7:0]            paddr, seed, setpt, ocf;
	logic [31:0]           pwdata, prdata, rd;
	logic [2:0]            ties, max_phases;
	logic                  ph2, ph3, ph4;
	sncl_pkg::sncl_src_e   src;
	sncl_pkg::sncl_strap_s sc;
	sncl_pkg::sncl_nvm_s   nv;
	sncl_pkg::sncl_cfg_s   cf;
	int                    mismatches, total_checks;
	localparam logic [7:0] SEEDS [8] = '{8'h35, 8'h5A, 8'h6C, 8'h13, 8'h7F, 8'hC3, 8'h96, 8'hF0};
	localparam logic [2:0] TIES [8] = '{3'b000, 3'b001, 3'b010, 3'b100, 3'b110, 3'b011, 3'b101, 3'b000};

	sncl_strap_board board_u (.seed(seed), .ties(ties), .config_source_strap(src), .strap_codes(sc),
		.nvm_image(nv), .phase2_current_sense(ph2), .phase3_current_sense(ph3), .phase4_current_sense(ph4));
	sncl_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.aux_3v3_rail(rail), .config_source_strap(src), .strap_codes(sc), .nvm_image(nv),
		.phase2_current_sense(ph2), .phase3_current_sense(ph3), .phase4_current_sense(ph4), .cfg_out(cf),
		.output_setpoint_cmd(setpt), .output_overcurrent_fault(ocf), .max_phases(max_phases),
		.cfg_valid(cfg_valid));

	always #5 pclk = ~pclk;

	// ====================
	// shared tasks
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle limit here: only the watchdog ends a hung transfer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task power_up(input logic [7:0] s, input logic [2:0] t);
		int n;
		@(posedge pclk);
		rail <= 1'b0;
		seed <= s;
		ties <= t;
		repeat (6) @(posedge pclk);
		rail <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (cfg_valid !== 1'b1 && n < 20);
		`CHK("valid", 1'b1, cfg_valid);
	endtask : power_up

	task check_cfg();
		logic        s;
		logic [7:0]  ei, eb;
		logic [10:0] o;
		s  = (src === sncl_pkg::SNCL_SRC_LOW);
		ei = s ? sc.mload_v : nv.mload;
		eb = s ? {sc.boot_v, sc.boot_r, sc.addr_r[0]} : nv.boot;
		o  = ({3'b000, ei} * 11'd5) >> 2;
		if (s) begin
			`CHK("freq", sc.freq_r, cf.freq_cfg[6:4]);
			`CHK("mode", sc.mode_v, {cf.mode[7:6], cf.mode[4:3]});
		end else begin
			`CHK("freq", nv.freq, cf.freq_cfg[7:4]);
			`CHK("mode", nv.mode, cf.mode[7:3]);
		end
		`CHK("mload", ei, cf.mload);
		`CHK("boot", eb, cf.boot);
		`CHK("vlim", s ? sc.vlim_r ^ sc.vlim_v : nv.vlim, cf.vlim);
		`CHK("oshoot", s ? sc.oshoot_r : nv.oshoot, cf.oshoot);
		`CHK("ushoot", s ? sc.ushoot_v : nv.ushoot, cf.ushoot);
		`CHK("slew", s ? sc.slew_r : nv.slew, cf.slew);
		`CHK("rise", s ? sc.addr_r[2:1] : nv.rise, cf.rise);
		`CHK("ramp", s ? sc.vlim_v[3:2] : nv.ramp, cf.ramp);
		`CHK("addr", sc.addr_v, cf.addr);
		`CHK("ocf", o > 11'd255 ? 8'hFF : o[7:0], ocf);
		`CHK("setpt", eb, setpt);
		`CHK("phases", ties[0] ? 3'd1 : ties[1] ? 3'd2 : ties[2] ? 3'd3 : 3'd4, max_phases);
	endtask : check_cfg

	task close_out();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out

	// ====================
	// scenarios
	task t_reset();
		`CHK("valid", 1'b0, cfg_valid);
		`CHK("phases", sncl_pkg::SNCL_PH_MAX, max_phases);
		apb(1'b0, sncl_pkg::SNCL_STATUS_ADDR, 32'h0000_0000);
		`CHK("status", 32'h0000_0001, rd);
		$display("test reset done");
	endtask : t_reset

	task t_capture();
		for (int i = 0; i < 7; i++) begin
			power_up(SEEDS[i], TIES[i]);
			check_cfg();
		end
		$display("test capture done");
	endtask : t_capture

	// straps and ties move after capture; the source class stays high
	task t_hold();
		sncl_pkg::sncl_cfg_s k;
		logic [2:0]          p;
		k = cf;
		p = max_phases;
		@(posedge pclk);
		seed <= SEEDS[7];
		ties <= 3'b001;
		repeat (8) @(posedge pclk);
		`CHK("hold cfg", k, cf);
		`CHK("hold phases", p, max_phases);
		power_up(SEEDS[7], 3'b001);
		check_cfg();
		$display("test hold done");
	endtask : t_hold

	task t_apb();
		apb(1'b0, sncl_pkg::SNCL_STATUS_ADDR, 32'h0000_0000);
		`CHK("status", 32'h0000_0004, rd);
		apb(1'b1, sncl_pkg::SNCL_FREQ_ADDR, 32'h0000_00A5);
		apb(1'b1, sncl_pkg::SNCL_SETPT_ADDR, 32'hFFFF_FF5C);
		apb(1'b0, sncl_pkg::SNCL_FREQ_ADDR, 32'h0000_0000);
		`CHK("freq rd", 32'h0000_00A5, rd);
		`CHK("freq out", 8'hA5, cf.freq_cfg);
		`CHK("setpt", 8'h5C, setpt);
		apb(1'b1, sncl_pkg::SNCL_SHOOT_ADDR, 32'h0000_0053);
		apb(1'b1, sncl_pkg::SNCL_SLEWM_ADDR, 32'h0000_00D6);
		apb(1'b1, sncl_pkg::SNCL_RAMP_ADDR, 32'h0000_0009);
		apb(1'b1, sncl_pkg::SNCL_ADDR_ADDR, 32'h0000_000B);
		apb(1'b1, sncl_pkg::SNCL_PHASE_ADDR, 32'h0000_0002);
		apb(1'b1, sncl_pkg::SNCL_OCF_ADDR, 32'h0000_0077);
		apb(1'b1, sncl_pkg::SNCL_MLOAD_ADDR, 32'h0000_00C4);
		apb(1'b1, sncl_pkg::SNCL_BOOT_ADDR, 32'h0000_0097);
		apb(1'b1, sncl_pkg::SNCL_VLIM_ADDR, 32'h0000_000E);
		apb(1'b0, sncl_pkg::SNCL_SHOOT_ADDR, 32'h0000_0000);
		`CHK("shoot rd", 32'h0000_0053, rd);
		`CHK("shoot", 6'h2B, {cf.ushoot, cf.oshoot});
		`CHK("slew mode", 8'hD6, {cf.mode[7:3], cf.slew});
		`CHK("rise ramp", 4'h9, {cf.ramp, cf.rise});
		`CHK("addr wr", 4'hB, cf.addr);
		`CHK("phases wr", 3'h2, max_phases);
		`CHK("ocf wr", 8'h77, ocf);
		`CHK("mload wr", 8'hC4, cf.mload);
		`CHK("boot wr", 8'h97, cf.boot);
		`CHK("vlim wr", 4'hE, cf.vlim);
		apb(1'b1, 8'h40, 32'h0000_0011);
		`CHK("err wr", 1'b1, err);
		apb(1'b0, 8'h40, 32'h0000_0000);
		`CHK("err rd", 1'b1, err);
		`CHK("rd unmapped", 32'h0000_0000, rd);
		$display("test apb done");
	endtask : t_apb

	// reload command recaptures over every bus-written field
	task t_reload();
		apb(1'b1, sncl_pkg::SNCL_CTRL_ADDR, 32'h0000_0001);
		@(negedge cfg_valid);
		@(posedge cfg_valid);
		@(posedge pclk);
		check_cfg();
		$display("test reload done");
	endtask : t_reload

	// reset in mid-run with the rail already good must recapture
	task t_mid_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		`CHK("rst valid", 1'b0, cfg_valid);
		`CHK("rst setpt", sncl_pkg::SNCL_BYTE_RST, setpt);
		`CHK("rst ocf", sncl_pkg::SNCL_BYTE_RST, ocf);
		`CHK("rst phases", sncl_pkg::SNCL_PH_MAX, max_phases);
		presetn <= 1'b1;
		do begin
			@(posedge pclk);
		end while (cfg_valid !== 1'b1);
		check_cfg();
		$display("test mid reset done");
	endtask : t_mid_reset

	// ====================
	// main sequence and watchdog
	initial begin
		{pclk, presetn, psel, penable, pwrite, rail} = '0;
		{paddr, pwdata, seed, ties} = '0;
		{mismatches, total_checks} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_capture();
		t_hold();
		t_apb();
		t_reload();
		t_mid_reset();
		close_out();
	end

	initial begin
		repeat (5000) @(posedge pclk);
		mismatches++;
		close_out();
	end
endmodule : tb_top
